// *** cclf_pkg.sv ***
// Constants shared by the condition code flag logic
package cclf_pkg;
   // Accumulator geometry
   localparam int ACC_W = 56;
   localparam int ACC_MSB = 55;
   localparam int WORD_MSB = 47;
   localparam int WORD_LSB = 24;
   // APB register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FLAGS = 12'h004;
   // Field positions in the control register
   localparam int CTRL_SCALE_LSB = 0;
   // Bit positions in the flag register, and FLG_W its width
   localparam int FLG_C = 0;
   localparam int FLG_V = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_N = 3;
   localparam int FLG_U = 4;
   localparam int FLG_E = 5;
   localparam int FLG_L = 6;
   localparam int FLG_W = 7;
   // Scaling modes
   localparam logic [1:0] SCALE_NONE = 2'h0;
   localparam logic [1:0] SCALE_DOWN = 2'h1;
   localparam logic [1:0] SCALE_UP = 2'h2;
   // Operation codes from the datapath sequencer
   localparam logic [1:0] OP_MOVE = 2'h0;
   localparam logic [1:0] OP_ADD = 2'h1;
   localparam logic [1:0] OP_SUB = 2'h2;
   localparam logic [1:0] OP_AND = 2'h3;
   // Values after reset
   localparam logic [1:0] SCALE_RST = 2'h0;
   localparam logic [6:0] FLAGS_RST = 7'h00;
   localparam logic [55:0] ACC_RST = 56'h00000000000000;
endpackage

// *** cclf_flag_eval.sv ***
// Result-dependent flag evaluation: unnormalized, extension, negative, zero
`timescale 1ns/1ns
module cclf_flag_eval (
   input wire logic [cclf_pkg::ACC_MSB:0] result,
   input wire logic [1:0] scale,
   input wire logic logic_op,
   output logic unnorm,
   output logic extension,
   output logic negative,
   output logic zero
);
   import cclf_pkg::*;

   // Scale-dependent tests; the reserved code 11 behaves as no scaling
   always_comb begin
      unique case (scale)
         SCALE_DOWN: begin
            unnorm = ~(result[48] ^ result[47]);
            extension = ~((&result[ACC_MSB:48]) | ~(|result[ACC_MSB:48]));
         end
         SCALE_UP: begin
            unnorm = ~(result[46] ^ result[45]);
            extension = ~((&result[ACC_MSB:46]) | ~(|result[ACC_MSB:46]));
         end
         default: begin
            unnorm = ~(result[47] ^ result[46]);
            extension = ~((&result[ACC_MSB:47]) | ~(|result[ACC_MSB:47]));
         end
      endcase
   end

   // Logical operations only look at the middle word
   assign negative = logic_op ? result[WORD_MSB] : result[ACC_MSB];
   assign zero = logic_op ? ~(|result[WORD_MSB:WORD_LSB]) : ~(|result);
endmodule

// *** cclf_top.sv ***
// Condition code flag logic with two accumulators and an APB register port
`timescale 1ns/1ns
// Function
// - Unnormalized is set when the two top bits of the scaled middle word are equal (47/46, 48/47 or 46/45).
// - Negative follows bit 55 of the result, or bit 47 for the logical AND.
// - Zero is set when the whole result is zero, or for the logical AND when the middle word is zero.
// - Overflow is set when the result does not fit the 56-bit accumulator.
// - Carry is the carry out of bit 55 for add and the borrow out of bit 55 for subtract.
// - A parallel move from the destination accumulator delivers its value from before the operation.
// - The plain move does no arithmetic and only performs its parallel transfer.
// - Limit is set by overflow or a limiting event and holds until software clears it.
// - Extension is cleared when the scaled signed integer portion is all ones or all zeros.
// - Only add, subtract and AND results update the result flags, AND only N, Z and V; moves and other transfers leave them.
module cclf_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   input wire logic [1:0] op_code,
   input wire logic op_dest,
   input wire logic [cclf_pkg::ACC_MSB:0] op_operand,
   input wire logic move_req,
   input wire logic move_src,
   input wire logic limit_evt,
   output logic [cclf_pkg::ACC_MSB:0] move_data,
   output logic move_valid,
   output logic [cclf_pkg::ACC_MSB:0] acc_a,
   output logic [cclf_pkg::ACC_MSB:0] acc_b,
   output logic [cclf_pkg::FLG_W-1:0] flag_register,
   output logic scaling_select_high,
   output logic scaling_select_low
);
   import cclf_pkg::*;

   logic [ACC_MSB:0] acc_a_r;
   logic [ACC_MSB:0] acc_b_r;
   logic [ACC_MSB:0] move_data_r;
   logic move_valid_r;
   logic [FLG_W-1:0] flags_r;
   // The result flags and the latched limit flag sit in separate flops, so each has a single writer
   logic [FLG_L-1:0] res_flags_r;
   logic lim_r;
   logic [1:0] scale_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [ACC_MSB:0] acc_old;
   logic [ACC_MSB:0] res_nxt;
   logic [ACC_W:0] sum_ext;
   logic [ACC_W:0] diff_ext;
   logic carry_nxt;
   logic ovf_nxt;
   logic arith_upd;
   logic logic_op;
   logic f_unnorm;
   logic f_ext;
   logic f_neg;
   logic f_zero;
   logic apb_access;
   logic wr_en;
   logic rd_hit;
   logic l_clear;

   // Destination accumulator before this operation
   assign acc_old = op_dest ? acc_b_r : acc_a_r;
   assign sum_ext = {1'b0, acc_old} + {1'b0, op_operand};
   assign diff_ext = {1'b0, acc_old} - {1'b0, op_operand};
   assign logic_op = (op_code == OP_AND);
   assign arith_upd = op_valid & (op_code != OP_MOVE);

   // Result, carry and overflow per operation
   always_comb begin
      res_nxt = acc_old;
      carry_nxt = flags_r[FLG_C];
      ovf_nxt = 1'b0;
      unique case (op_code)
         OP_ADD: begin
            res_nxt = sum_ext[ACC_MSB:0];
            carry_nxt = sum_ext[ACC_W];
            ovf_nxt = (acc_old[ACC_MSB] == op_operand[ACC_MSB]) && (sum_ext[ACC_MSB] != acc_old[ACC_MSB]);
         end
         OP_SUB: begin
            res_nxt = diff_ext[ACC_MSB:0];
            carry_nxt = diff_ext[ACC_W];
            ovf_nxt = (acc_old[ACC_MSB] != op_operand[ACC_MSB]) && (diff_ext[ACC_MSB] != acc_old[ACC_MSB]);
         end
         OP_AND: begin
            // Only the middle word is combined; extension and low word pass through
            res_nxt = {acc_old[ACC_MSB:WORD_MSB+1], acc_old[WORD_MSB:WORD_LSB] & op_operand[WORD_MSB:WORD_LSB],
                       acc_old[WORD_LSB-1:0]};
            ovf_nxt = 1'b0;
         end
         OP_MOVE: begin
            res_nxt = acc_old;
         end
      endcase
   end

   cclf_flag_eval i_cclf_flag_eval (
      .result(res_nxt),
      .scale(scale_r),
      .logic_op(logic_op),
      .unnorm(f_unnorm),
      .extension(f_ext),
      .negative(f_neg),
      .zero(f_zero)
   );

   // Accumulator update; a move on the same edge still sees the old value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_a_r <= ACC_RST;
         acc_b_r <= ACC_RST;
      end else if (arith_upd) begin
         if (op_dest) begin
            acc_b_r <= res_nxt;
         end else begin
            acc_a_r <= res_nxt;
         end
      end
   end

   // Parallel move port, sampled from registers before the update lands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         move_data_r <= ACC_RST;
         move_valid_r <= 1'b0;
      end else begin
         move_valid_r <= move_req;
         if (move_req) begin
            move_data_r <= move_src ? acc_b_r : acc_a_r;
         end
      end
   end

   // Result flags change only on an arithmetic-unit result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_flags_r <= FLAGS_RST[FLG_L-1:0];
      end else if (arith_upd) begin
         res_flags_r[FLG_N] <= f_neg;
         res_flags_r[FLG_Z] <= f_zero;
         res_flags_r[FLG_V] <= ovf_nxt;
         if (!logic_op) begin
            res_flags_r[FLG_C] <= carry_nxt;
            res_flags_r[FLG_U] <= f_unnorm;
            res_flags_r[FLG_E] <= f_ext;
         end
      end
   end

   // Latched limit flag; a new set beats a software clear in the same cycle
   assign l_clear = wr_en && (paddr == ADDR_FLAGS) && pwdata[FLG_L];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lim_r <= FLAGS_RST[FLG_L];
      end else if ((arith_upd && ovf_nxt) || limit_evt) begin
         lim_r <= 1'b1;
      end else if (l_clear) begin
         lim_r <= 1'b0;
      end
   end

   // APB: one wait state, the write lands on the edge that samples pready
   assign apb_access = psel & penable;
   assign wr_en = apb_access & pwrite & pready_r;
   assign rd_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_FLAGS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= apb_access & ~pready_r;
         if (apb_access && !pready_r) begin
            pslverr_r <= ~rd_hit;
            // Write cycles and unmapped reads return zero so no stale data leaks out
            if (pwrite || !rd_hit) begin
               prdata_r <= 32'h00000000;
            end else if (paddr == ADDR_CTRL) begin
               prdata_r <= {30'h00000000, scale_r};
            end else begin
               prdata_r <= {25'h0000000, flags_r};
            end
         end else begin
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
         end
      end
   end

   // Scaling mode register steers the unnormalized and extension tests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scale_r <= SCALE_RST;
      end else if (wr_en && paddr == ADDR_CTRL) begin
         scale_r <= pwdata[CTRL_SCALE_LSB+1:CTRL_SCALE_LSB];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign move_data = move_data_r;
   assign move_valid = move_valid_r;
   assign acc_a = acc_a_r;
   assign acc_b = acc_b_r;
   // Limit sits above the six result flags
   assign flags_r = {lim_r, res_flags_r};
   assign flag_register = flags_r;
   assign scaling_select_high = scale_r[1];
   assign scaling_select_low = scale_r[0];
endmodule

// *** cclf_asserts.sv ***
// Checker bound to the flag logic top
`timescale 1ns/1ns
module cclf_asserts
   import cclf_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic op_valid,
   input wire logic [1:0] op_code,
   input wire logic op_dest,
   input wire logic [55:0] op_operand,
   input wire logic move_req,
   input wire logic move_src,
   input wire logic limit_evt,
   input wire logic [55:0] move_data,
   input wire logic move_valid,
   input wire logic [55:0] acc_a,
   input wire logic [6:0] flag_register,
   input wire logic scaling_select_high,
   input wire logic scaling_select_low
);
   // Op classes on accumulator A; B follows the same logic
   wire add_a = op_valid && !op_dest && op_code == OP_ADD;
   wire sub_a = op_valid && !op_dest && op_code == OP_SUB;
   wire [1:0] sc = {scaling_select_high, scaling_select_low};
   // Sign-extended sums; the top two bits differ exactly when 56 bits cannot hold the result
   wire [56:0] sx = {acc_a[55], acc_a} + {op_operand[55], op_operand};
   wire [56:0] dx = {acc_a[55], acc_a} - {op_operand[55], op_operand};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_NEG: assert property (add_a || sub_a |=> flag_register[FLG_N] == acc_a[55])
      else $error("negative flag wrong");
   AST_ZERO: assert property (add_a || sub_a |=> flag_register[FLG_Z] == (acc_a == 56'h0))
      else $error("zero flag wrong");
   AST_UNORM: assert property (add_a |=> flag_register[FLG_U] ==
      ($past(sc) == SCALE_DOWN ? acc_a[48] == acc_a[47] : $past(sc) == SCALE_UP ? acc_a[46] == acc_a[45] :
      acc_a[47] == acc_a[46])) else $error("unnormalized flag wrong");
   AST_CARRY: assert property (add_a |=> flag_register[FLG_C] == (acc_a < $past(acc_a)))
      else $error("carry flag wrong");
   AST_BORROW: assert property (sub_a |=> flag_register[FLG_C] == ($past(acc_a) < $past(op_operand)))
      else $error("borrow flag wrong");
   AST_MOVE_OLD: assert property (move_req && !move_src |=> move_valid && move_data == $past(acc_a))
      else $error("move data not old value");
   AST_MOVE_NOP: assert property (op_valid && op_code == OP_MOVE |=> $stable(acc_a) && $stable(flag_register[5:0]))
      else $error("move changed state");
   AST_LIMIT: assert property (limit_evt |=> flag_register[FLG_L])
      else $error("limit flag not set");
   AST_OVF: assert property (add_a || sub_a |=> flag_register[FLG_V] == $past(add_a ? sx[56] ^ sx[55] : dx[56] ^ dx[55]))
      else $error("overflow flag wrong");
   AST_EXT: assert property (add_a |=> flag_register[FLG_E] ==
      !($past(sc) == SCALE_DOWN ? (acc_a[55:48] == 8'hff || acc_a[55:48] == 8'h00) :
      $past(sc) == SCALE_UP ? (acc_a[55:46] == 10'h3ff || acc_a[55:46] == 10'h000) :
      (acc_a[55:47] == 9'h1ff || acc_a[55:47] == 9'h000))) else $error("extension flag wrong");
   AST_V_LATCH: assert property (op_valid && op_code != OP_MOVE ##1 flag_register[FLG_V] |-> flag_register[FLG_L])
      else $error("overflow did not latch");
   AST_AND: assert property (op_valid && op_code == OP_AND |=>
      !flag_register[FLG_V] && $stable({flag_register[5:4], flag_register[0]})) else $error("logic op flags wrong");
   AST_SLVERR: assert property (pready && paddr != ADDR_CTRL && paddr != ADDR_FLAGS |-> pslverr)
      else $error("unmapped access not refused");
   cover property (op_valid && move_req);
   cover property (pready && pslverr);
   cover property (limit_evt);
endmodule

// *** cclf_top_tb.sv ***
// Self-checking bench for the flag logic
`timescale 1ns/1ns
module cclf_top_tb;
   import cclf_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, move_valid, er;
   logic op_valid = 0, op_dest = 0, move_req = 0, move_src = 0, limit_evt = 0;
   logic scaling_select_high, scaling_select_low;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [1:0] op_code = 2'h0;
   logic [55:0] op_operand = 56'h0, move_data, acc_a, acc_b;
   logic [6:0] flag_register;
   int bad_count = 0, checked = 0;
   cclf_top i_cclf_top (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .op_valid(op_valid),
      .op_code(op_code),
      .op_dest(op_dest),
      .op_operand(op_operand),
      .move_req(move_req),
      .move_src(move_src),
      .limit_evt(limit_evt),
      .move_data(move_data),
      .move_valid(move_valid),
      .acc_a(acc_a),
      .acc_b(acc_b),
      .flag_register(flag_register),
      .scaling_select_high(scaling_select_high),
      .scaling_select_low(scaling_select_low)
   );
   initial forever #10 pclk = ~pclk;
   // Bounds a hung handshake
   initial begin
      #100000;
      bad_count++;
      print_verdict();
   end
   task automatic chk(string n, logic [127:0] g, logic [127:0] x);
      checked++;
      if (g !== x) begin
         bad_count++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   // One APB transfer; waits for pready, no latency assumed
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      // Let the edge's register updates settle before callers look at outputs
      #1;
   endtask
   // One datapath op, optionally with a move from the accumulator selected by move_src and a limit pulse
   task automatic op(logic [1:0] c, logic d, logic [55:0] v, logic m, logic l);
      @(posedge pclk);
      op_valid <= 1;
      op_code <= c;
      op_dest <= d;
      op_operand <= v;
      move_req <= m;
      limit_evt <= l;
      @(posedge pclk);
      op_valid <= 0;
      move_req <= 0;
      limit_evt <= 0;
      #1;
   endtask
   task automatic t_arith;
      logic [1:0] c [4] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB};
      logic [55:0] v [4] = '{56'h7fffffffffffff, 56'h1, 56'h80000000000000, 56'h1};
      logic [55:0] a [4] = '{56'h7fffffffffffff, 56'h80000000000000, 56'h0, 56'hffffffffffffff};
      logic [6:0] f [4] = '{7'h30, 7'h7a, 7'h57, 7'h59};
      for (int i = 0; i < 4; i++) begin
         op(c[i], 0, v[i], 0, 0);
         chk("acc_a", acc_a, a[i]);
         chk("flags", flag_register, f[i]);
      end
      apb(0, ADDR_FLAGS, 32'h0);
      chk("flag read", rd, 32'h59);
      apb(1, ADDR_FLAGS, 32'h7f);
      chk("limit clear", flag_register, 7'h19);
      $display("arith test done");
   endtask
   task automatic t_scale;
      op(OP_ADD, 0, 56'h01200000000001, 0, 0);
      for (int s = 0; s < 4; s++) begin
         apb(1, ADDR_CTRL, {30'h0, s[1:0]});
         op(OP_ADD, 0, 56'h0, 0, 0);
         chk("scale", {scaling_select_high, scaling_select_low}, s[1:0]);
         chk("unnorm", flag_register[FLG_U], s == 0 || s == 3);
      end
      apb(0, 12'h008, 32'h0);
      chk("slverr", {er, rd}, 33'h100000000);
      $display("scale test done");
   endtask
   task automatic t_and_move;
      op(OP_ADD, 0, 56'hff000000000000, 0, 0);
      chk("carry", flag_register, 7'h11);
      op(OP_AND, 0, 56'h00800000000000, 0, 0);
      chk("and flags", flag_register, 7'h15);
      op(OP_ADD, 0, 56'h5, 1, 0);
      chk("move old", {move_valid, move_data, acc_a}, {1'h1, 56'h0, 56'h5});
      op(OP_MOVE, 0, 56'h123, 1, 1);
      chk("move nop", {move_data, acc_a, flag_register}, {56'h5, 56'h5, 7'h50});
      op(OP_ADD, 1, 56'h3, 0, 0);
      chk("acc_b", {acc_b, acc_a}, {56'h3, 56'h5});
      @(posedge pclk);
      move_src <= 1;
      op(OP_ADD, 1, 56'h4, 1, 0);
      chk("move old b", {move_valid, move_data, acc_b}, {1'h1, 56'h3, 56'h7});
      $display("and and move test done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      chk("reset flags", flag_register, 7'h0);
      t_arith();
      t_scale();
      t_and_move();
      print_verdict();
   end
endmodule
bind cclf_top cclf_asserts i_cclf_asserts (
   .pclk(pclk),
   .presetn(presetn),
   .paddr(paddr),
   .pready(pready),
   .pslverr(pslverr),
   .op_valid(op_valid),
   .op_code(op_code),
   .op_dest(op_dest),
   .op_operand(op_operand),
   .move_req(move_req),
   .move_src(move_src),
   .limit_evt(limit_evt),
   .move_data(move_data),
   .move_valid(move_valid),
   .acc_a(acc_a),
   .flag_register(flag_register),
   .scaling_select_high(scaling_select_high),
   .scaling_select_low(scaling_select_low)
);
